// ===== rtl/rsd_pkg.sv
// Contract
// - Link-rotate left to accumulator: old link into bit 0, bit 7 into link, memory kept.
// - Plain right rotate in memory: bit 0 wraps to bit 7, written back, no flags.
// - Plain right rotate to accumulator: bit 0 wraps to bit 7, memory and flags untouched.
// - Link-rotate right in memory: old link into bit 7, bit 0 into link, stored back.
// - Link-rotate right to accumulator: old link into bit 7, bit 0 into link, memory kept.
// - Subtract with borrow: accumulator minus memory minus inverted link, into accumulator.
// - After subtract, link cleared when difference negative, set when zero or positive.
// - Subtract with borrow updates all six status flags.
package rsd_pkg;
  // Register byte offsets
  localparam logic [7:0] RSD_CMD_OFS = 8'h00;
  localparam logic [7:0] RSD_ACC_OFS = 8'h04;
  localparam logic [7:0] RSD_MEM_OFS = 8'h08;
  localparam logic [7:0] RSD_FLG_OFS = 8'h0C;
  localparam logic [7:0] RSD_CNT_OFS = 8'h10;

  // Operation codes written to the command register
  localparam logic [2:0] RSD_OP_NONE = 3'h0;
  localparam logic [2:0] RSD_OP_ROTATE_LEFT_VIA_LINK_BIT_TO_ACCUMULATOR = 3'h1;
  localparam logic [2:0] RSD_OP_ROTATE_RIGHT_IN_PLACE = 3'h2;
  localparam logic [2:0] RSD_OP_ROTATE_RIGHT_TO_ACCUMULATOR = 3'h3;
  localparam logic [2:0] RSD_OP_ROTATE_RIGHT_VIA_LINK_BIT = 3'h4;
  localparam logic [2:0] RSD_OP_ROTATE_RIGHT_VIA_LINK_BIT_TO_ACCUMULATOR = 3'h5;
  localparam logic [2:0] RSD_OP_SUBTRACT_WITH_BORROW = 3'h6;

  // Flag bit positions in the flag register
  localparam int RSD_LINK_BIT = 0;
  localparam int RSD_HALF_LINK_BIT = 1;
  localparam int RSD_ZERO_BIT = 2;
  localparam int RSD_SIGNED_WRAP_BIT = 3;
  localparam int RSD_SIGNED_LINK_BIT = 4;
  localparam int RSD_MULTI_BYTE_NULL_BIT = 5;
  localparam int RSD_FLAG_W = 6;

  // Values after reset
  localparam logic [7:0] RSD_ACC_RST = 8'h00;
  localparam logic [7:0] RSD_MEM_RST = 8'h00;
  localparam logic [5:0] RSD_FLG_RST = 6'h00;
  localparam logic [15:0] RSD_CNT_RST = 16'h0000;
endpackage

// ===== rtl/rsd_alu.sv
`timescale 1ns/100ps
module rsd_alu
  import rsd_pkg::*;
(
  input wire logic [2:0] op,
  input wire logic [7:0] acc,
  input wire logic [7:0] mem,
  input wire logic [5:0] flags,
  output logic [7:0] acc_res,
  output logic [7:0] mem_res,
  output logic [5:0] flags_res,
  output logic op_ok
);
  logic link;
  logic [8:0] diff;
  logic [4:0] half;
  logic [7:0] d;
  logic ov;

  // Subtraction terms; a borrow out of bit 8 or 4 means a negative part
  assign link = flags[RSD_LINK_BIT];
  assign diff = {1'b0, acc} - {1'b0, mem} - {8'h00, ~link};
  assign half = {1'b0, acc[3:0]} - {1'b0, mem[3:0]} - {4'h0, ~link};
  assign d = diff[7:0];
  assign ov = (acc[7] ^ mem[7]) & (acc[7] ^ d[7]);

  // Result select; operations that do not own a target leave it as it was
  always_comb
  begin
    acc_res = acc;
    mem_res = mem;
    flags_res = flags;
    op_ok = 1'b1;
    case (op)
      RSD_OP_ROTATE_LEFT_VIA_LINK_BIT_TO_ACCUMULATOR:
      begin
        acc_res = {mem[6:0], link};
        flags_res[RSD_LINK_BIT] = mem[7];
      end
      RSD_OP_ROTATE_RIGHT_IN_PLACE:
        mem_res = {mem[0], mem[7:1]};
      RSD_OP_ROTATE_RIGHT_TO_ACCUMULATOR:
        acc_res = {mem[0], mem[7:1]};
      RSD_OP_ROTATE_RIGHT_VIA_LINK_BIT:
      begin
        mem_res = {link, mem[7:1]};
        flags_res[RSD_LINK_BIT] = mem[0];
      end
      RSD_OP_ROTATE_RIGHT_VIA_LINK_BIT_TO_ACCUMULATOR:
      begin
        acc_res = {link, mem[7:1]};
        flags_res[RSD_LINK_BIT] = mem[0];
      end
      RSD_OP_SUBTRACT_WITH_BORROW:
      begin
        acc_res = d;
        flags_res[RSD_LINK_BIT] = ~diff[8];
        flags_res[RSD_HALF_LINK_BIT] = ~half[4];
        flags_res[RSD_ZERO_BIT] = (d == 8'h00);
        flags_res[RSD_SIGNED_WRAP_BIT] = ov;
        flags_res[RSD_SIGNED_LINK_BIT] = ov ^ d[7];
        // Chains across bytes: stays set only while every byte was zero
        flags_res[RSD_MULTI_BYTE_NULL_BIT] = (d == 8'h00) & flags[RSD_MULTI_BYTE_NULL_BIT];
      end
      default:
        op_ok = 1'b0;
    endcase
  end
endmodule

// ===== rtl/rsd_top.sv
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/100ps
module rsd_top
  import rsd_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] mem;
    logic [5:0] flags;
    logic [2:0] last_op;
    logic [15:0] op_count;
    logic [31:0] rdata;
    logic err;
  } rsd_state_t;

  rsd_state_t state_r;
  rsd_state_t state_nxt;
  logic [7:0] addr;
  logic setup;
  logic wr_edge;
  logic [7:0] acc_res;
  logic [7:0] mem_res;
  logic [5:0] flags_res;
  logic op_ok;

  assign addr = paddr[7:0];
  assign setup = psel & ~penable;
  assign wr_edge = psel & penable & pwrite;

  // Op code comes from the write data so the op runs at the command edge
  rsd_alu u_alu (
    .op(pwdata[2:0]),
    .acc(state_r.acc),
    .mem(state_r.mem),
    .flags(state_r.flags),
    .acc_res(acc_res),
    .mem_res(mem_res),
    .flags_res(flags_res),
    .op_ok(op_ok)
  );

  // Zero wait states: read data and error are prepared in the setup cycle
  always_comb
  begin
    state_nxt = state_r;
    if (setup)
    begin
      state_nxt.rdata = 32'h0000_0000;
      state_nxt.err = 1'b0;
      if (addr == RSD_CMD_OFS)
        state_nxt.rdata = {29'h0000_0000, state_r.last_op};
      else if (addr == RSD_ACC_OFS)
        state_nxt.rdata = {24'h00_0000, state_r.acc};
      else if (addr == RSD_MEM_OFS)
        state_nxt.rdata = {24'h00_0000, state_r.mem};
      else if (addr == RSD_FLG_OFS)
        state_nxt.rdata = {26'h000_0000, state_r.flags};
      else if (addr == RSD_CNT_OFS)
        state_nxt.err = pwrite; // Counter is read only
      else
        state_nxt.err = 1'b1;
      if (addr == RSD_CNT_OFS)
        state_nxt.rdata = {16'h0000, state_r.op_count};
    end
    // Writes land at the access edge; an unknown op code changes nothing
    if (wr_edge && !state_r.err)
    begin
      if (addr == RSD_CMD_OFS)
      begin
        if (op_ok)
        begin
          state_nxt.acc = acc_res;
          state_nxt.mem = mem_res;
          state_nxt.flags = flags_res;
          state_nxt.last_op = pwdata[2:0];
          state_nxt.op_count = state_r.op_count + 16'h0001;
        end
      end
      else if (addr == RSD_ACC_OFS)
        state_nxt.acc = pwdata[7:0];
      else if (addr == RSD_MEM_OFS)
        state_nxt.mem = pwdata[7:0];
      else if (addr == RSD_FLG_OFS)
        state_nxt.flags = pwdata[5:0];
    end
  end

  // Single state register
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_r.acc <= RSD_ACC_RST;
      state_r.mem <= RSD_MEM_RST;
      state_r.flags <= RSD_FLG_RST;
      state_r.last_op <= RSD_OP_NONE;
      state_r.op_count <= RSD_CNT_RST;
      state_r.rdata <= 32'h0000_0000;
      state_r.err <= 1'b0;
    end
    else
      state_r <= state_nxt;
  end

  // Bus answers; error only shown in the access phase
  assign pready = 1'b1;
  assign prdata = state_r.rdata;
  assign pslverr = psel & penable & state_r.err;
endmodule

// ===== verif/rsd_chk.sv
`timescale 1ns/100ps
module rsd_chk
  import rsd_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Access phase of any transfer
  wire acs = psel && penable;
  property p_rdy; pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready low");
  property p_err; pslverr |-> acs; endproperty
  a_err: assert property (p_err) else $error("error outside access");
  property p_unm; acs && paddr[7:0] > 8'h10 |-> pslverr; endproperty
  a_unm: assert property (p_unm) else $error("unmapped not refused");
  property p_cnt; acs && pwrite && paddr[7:0] == RSD_CNT_OFS |-> pslverr; endproperty
  a_cnt: assert property (p_cnt) else $error("count write accepted");
  property p_ok; acs && paddr[7:0] < 8'h10 && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("mapped access refused");
  property p_acc; acs && !pwrite && paddr[7:0] == RSD_ACC_OFS |-> prdata[31:8] == 24'h0; endproperty
  a_acc: assert property (p_acc) else $error("acc upper bits set");
  property p_flg; acs && !pwrite && paddr[7:0] == RSD_FLG_OFS |-> prdata[31:6] == 26'h0; endproperty
  a_flg: assert property (p_flg) else $error("flag upper bits set");
  property p_hold; acs && !pwrite ##1 !psel |-> $stable(prdata); endproperty
  a_hold: assert property (p_hold) else $error("read data not held");
  property p_hole; acs && !pwrite && paddr[7:0] > RSD_CNT_OFS |-> prdata == 32'h0000_0000; endproperty
  a_hole: assert property (p_hole) else $error("unmapped read not zero");
endmodule
bind rsd_top rsd_chk #(.ADDR_W(ADDR_W)) u_chk (.mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// ===== verif/testbench.sv
`timescale 1ns/100ps
module testbench;
  import rsd_pkg::*;
  logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr;
  int failures = 0, compares = 0;
  rsd_top dut (.mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial forever #20 mclk = ~mclk;
  task close_out;
    if (failures == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task cmp(input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %0t %h %h", $time, g, e);
    end
  endtask
  // One APB transfer; waits for pready under a bound
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    // A missing answer is a mismatch and ends the run
    if (pready !== 1'b1)
    begin
      failures++;
      close_out;
    end
    else
    begin
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
    end
  endtask
  // Load operands, execute, read all back
  task run(input logic [7:0] a, m, input logic [5:0] f, input logic [2:0] op,
    input logic [7:0] ea, em, input logic [5:0] ef);
    xfer(RSD_ACC_OFS, 1, {24'h0, a});
    xfer(RSD_MEM_OFS, 1, {24'h0, m});
    xfer(RSD_FLG_OFS, 1, {26'h0, f});
    xfer(RSD_CMD_OFS, 1, {29'h0, op});
    cmp(32'h0, {31'h0, er});
    xfer(RSD_ACC_OFS, 0, 0);
    cmp({24'h0, ea}, rd);
    xfer(RSD_MEM_OFS, 0, 0);
    cmp({24'h0, em}, rd);
    xfer(RSD_FLG_OFS, 0, 0);
    cmp({26'h0, ef}, rd);
  endtask
  // Other flags preset, except in the last case, so a stray flag update shows
  task t_rot;
    run(8'h00, 8'h81, 6'h3E, 3'h1, 8'h02, 8'h81, 6'h3F);
    run(8'h33, 8'h01, 6'h3E, 3'h2, 8'h33, 8'h80, 6'h3E);
    run(8'h00, 8'h03, 6'h2A, 3'h3, 8'h81, 8'h03, 6'h2A);
    run(8'h44, 8'h02, 6'h3F, 3'h4, 8'h44, 8'h81, 6'h3E);
    run(8'h55, 8'h02, 6'h01, 3'h5, 8'h81, 8'h02, 6'h00);
  endtask
  task t_sub;
    run(8'h10, 8'h20, 6'h01, 3'h6, 8'hF0, 8'h20, 6'h12);
    run(8'h05, 8'h04, 6'h20, 3'h6, 8'h00, 8'h04, 6'h27);
    run(8'h80, 8'h01, 6'h01, 3'h6, 8'h7F, 8'h01, 6'h19);
  endtask
  // Bad op codes, read-only count, unmapped word
  task t_bad;
    run(8'h11, 8'h22, 6'h05, 3'h7, 8'h11, 8'h22, 6'h05);
    run(8'h11, 8'h22, 6'h05, 3'h0, 8'h11, 8'h22, 6'h05);
    xfer(RSD_CNT_OFS, 1, 32'h0);
    cmp(32'h1, {31'h0, er});
    xfer(RSD_CNT_OFS, 0, 0);
    cmp(32'h8, rd);
    xfer(8'h14, 0, 0);
    cmp(32'h1, {31'h0, er});
    cmp(32'h0, rd);
    // Last counted op was the subtract; codes 0 and 7 must not replace it
    xfer(RSD_CMD_OFS, 0, 0);
    cmp(32'h6, rd);
  endtask
  initial
  begin
    repeat (3) @(posedge mclk);
    rst <= 0;
    t_rot;
    t_sub;
    t_bad;
    close_out;
  end
endmodule
